// [hw/swl_pkg.sv]
/*
  shared constants of the single-wire link: timing counts, header
  pattern, family codes.
  assumes both ends run on a 200 MHz system clock.
*/
package swl_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 200;
  localparam int unsigned TE_MAX_US   = 100;  // slowest bit period
  localparam int unsigned TE_MAX_CYC  = TE_MAX_US * SYS_CLK_MHZ;
  localparam int unsigned TE_MIN_US   = 10;
  localparam int unsigned TE_MIN_CYC  = TE_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned TE_W        = $clog2(2 * TE_MAX_CYC);  // [R02]
  localparam int unsigned HDR_BITS    = 8;
  localparam int unsigned HDR_SHIFT   = 3;    // log2 of header bits
  localparam int unsigned HDR_W       = TE_W + HDR_SHIFT;
  localparam int unsigned HDR_LIMIT   = (HDR_BITS + 1) * TE_MAX_CYC;
  localparam int unsigned TSTBY_US    = 600;
  localparam int unsigned TSTBY_CYC   = TSTBY_US * SYS_CLK_MHZ;
  localparam int unsigned HEADER_LOW_TIME_US     = 5;
  localparam int unsigned HEADER_LOW_TIME_CYC    = HEADER_LOW_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned TSS_US      = 10;
  localparam int unsigned TSS_CYC     = TSS_US * SYS_CLK_MHZ;
  localparam int unsigned TRIM_SHIFT  = 5;    // period step at most 1/32

  // ----------------------------------------------------------------
  // framing and addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] HDR_PATTERN = 8'h55;
  localparam logic [3:0] FAM_NONE    = 4'h0;
  localparam logic [3:0] FAM_EXT     = 4'hF;
  localparam logic [3:0] SLOT_MAK    = 4'h8;

  // family values no device may own
  function automatic logic fam_reserved(input logic [3:0] fam);
    fam_reserved = (fam == FAM_NONE) || (fam == FAM_EXT);
  endfunction
endpackage

// [hw/swl_if.sv]
/*
  carrier joining the master end and the slave end on one line.
  assumes a pull-up: the line idles high when nobody drives it.
*/
`timescale 1ns/100ps
`default_nettype none
interface swl_if;
  logic m_out;
  logic m_oe;
  logic s_out;
  logic s_oe;
  logic single_line_io;

  // resolved level, pull-up when released
  assign single_line_io = m_oe ? m_out : (s_oe ? s_out : 1'b1);

  modport master_mp (input single_line_io, output m_out, output m_oe);
  modport slave_mp  (input single_line_io, output s_out, output s_oe);
endinterface
`default_nettype wire

// [hw/swl_line_sampler.sv]
/*
  two-flop synchroniser and edge finder for the shared line.
  assumes the line is asynchronous to i_sys_clk and idles high.
*/
`timescale 1ns/100ps
`default_nettype none
module swl_line_sampler (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_line,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  typedef struct packed {
    logic meta;
    logic level;
    logic prev;
  } smp_t;

  smp_t q;
  smp_t d;

  // ----------------------------------------------------------------
  // sync chain
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.meta  = i_line;
    d.level = q.meta;
    d.prev  = q.level;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= 3'b111;
    end else begin
      q <= d;
    end
  end

  // edges seen on the synchronised level
  assign o_level = q.level;
  assign o_rise  = q.level & ~q.prev;
  assign o_fall  = ~q.level & q.prev;
endmodule
`default_nettype wire

// [hw/swl_slave.sv]
/*
  slave end of the single-wire link: header period measurement, bit
  recovery with drift tracking, address match, command byte stream
  and slave_ack drive.
  assumes the swl_if carrier and a free-running 200 MHz i_sys_clk;
  i_dev_code comes from logic on the same clock.
*/
// Contract
// [R01] count header eight bits for period
// [R02] header counter fits slowest bit period
// [R03] track frequency on every master_ack edge
// [R04] realign phase on master_ack middle edge
// [R05] oscillator off in idle and standby
// [R06] master sends address after header
// [R07] 8-bit: family high, device low nibble
// [R08] device code bits fixed or selectable
// [R09] family zero is reserved
// [R10] family all-ones: 8-bit slaves go idle
// [R11] 12-bit family in high byte low nibble
// [R12] 12-bit device code is low byte
// [R13] extended family zero, ones reserved
// [R14] 12-bit and 8-bit slaves coexist
// [R15] master sends command byte next
// [R16] any number of further bytes
// [R17] master_nack ends the command
// [R18] rising middle edge one, falling zero
// [R19] header carries alternating byte pattern
// [R20] master ack slot, then slave slot
// [R21] no slave_ack before address matched
// [R22] period is header count over eight
// [R23] mismatch ignores line until standby
// [R24] limit each frequency correction step
`timescale 1ns/100ps
`default_nettype none
module swl_slave #(
  parameter bit          EXT_ADDR     = 1'b0,
  parameter logic [3:0]  FAMILY       = 4'h2,   // arbitrary value
  parameter logic [7:0]  DEV_FIXED    = 8'h00,
  parameter logic [7:0]  DEV_SEL_MASK = 8'h0F,
  parameter int unsigned STBY_CYC     = swl_pkg::TSTBY_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  swl_if.slave_mp         bus,
  input  wire logic [7:0] i_dev_code,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_cmd,
  output logic            o_rx_last,
  output logic            o_selected,
  output logic            o_osc_en
);
  localparam int unsigned TE_W  = swl_pkg::TE_W;
  localparam int unsigned HDR_W = swl_pkg::HDR_W;
  localparam int unsigned STB_W = $clog2(STBY_CYC + 1);
  localparam logic [STB_W-1:0] STB_MAX   = STB_W'(STBY_CYC);
  localparam logic [HDR_W-1:0] HDR_MAX   = HDR_W'(swl_pkg::HDR_LIMIT);
  localparam logic [HDR_W:0]   HDR_ROUND = (HDR_W+1)'(swl_pkg::HDR_BITS / 2);
  localparam logic [3:0]       HDR_EDGES = 4'(swl_pkg::HDR_BITS);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (swl_pkg::fam_reserved(FAMILY) || STBY_CYC < 2) begin : g_bad_param
    $error("slave family code reserved or standby count too small");  // [R09] [R13]
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_STBY  = 3'b001,
    ST_HLOW  = 3'b010,
    ST_HMEAS = 3'b011,
    ST_BIT   = 3'b100,
    ST_SLOT  = 3'b101
  } st_t;

  typedef enum logic [1:0] {
    STG_HDR   = 2'b00,
    STG_ADDR  = 2'b01,
    STG_ADDRL = 2'b10,
    STG_DATA  = 2'b11
  } stg_t;

  typedef struct packed {
    st_t              st;
    stg_t             stg;
    logic [STB_W-1:0] hi_cnt;
    logic [HDR_W-1:0] hcnt;
    logic [3:0]       edges;
    logic [TE_W-1:0]  te;
    logic [TE_W-1:0]  t;
    logic [3:0]       idx;
    logic [7:0]       sh;
    logic             master_ack;
    logic             ack;
    logic             first;
    logic             out;
    logic             oe;
    logic             rx_valid;
    logic             rx_cmd;
    logic             rx_last;
    logic             sel;
    logic             osc;
  } slv_t;

  slv_t q;
  slv_t d;

  logic            lvl;
  logic            rise;
  logic            fall;
  logic            any_edge;
  logic [7:0]      dev_code;
  logic [TE_W-1:0] half;
  logic [TE_W-1:0] quarter;
  logic [TE_W-1:0] win_lo;
  logic [TE_W-1:0] win_hi;

  // header count to bit period, rounded to a whole cycle
  function automatic logic [TE_W-1:0] period_of(input logic [HDR_W-1:0] c);
    logic [HDR_W:0] r;
    r = {1'b0, c} + HDR_ROUND;
    period_of = r[swl_pkg::HDR_SHIFT +: TE_W];
  endfunction

  // follow a measured period, moving at most a small step
  function automatic logic [TE_W-1:0] trim(input logic [TE_W-1:0] te,
                                           input logic [TE_W-1:0] meas);
    logic [TE_W-1:0] lim;
    lim = te >> swl_pkg::TRIM_SHIFT;
    if (meas > te + lim) begin
      trim = te + lim;
    end else if (meas + lim < te) begin
      trim = te - lim;
    end else begin
      trim = meas;
    end
  endfunction

  swl_line_sampler u_smp (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_line    (bus.single_line_io),
    .o_level   (lvl),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  // ----------------------------------------------------------------
  // bit timing windows and own address
  // ----------------------------------------------------------------
  assign any_edge = rise | fall;
  assign half     = q.te >> 1;
  assign quarter  = q.te >> 2;
  assign win_lo   = q.te - (q.te >> 2);
  assign win_hi   = q.te + (q.te >> 2);
  assign dev_code = (DEV_FIXED & ~DEV_SEL_MASK) | (i_dev_code & DEV_SEL_MASK);  // [R08]

  // ----------------------------------------------------------------
  // receive engine
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    // line-high timer for the standby pulse
    if (!lvl) begin
      d.hi_cnt = '0;
    end else if (q.hi_cnt != STB_MAX) begin
      d.hi_cnt = q.hi_cnt + 1'b1;
    end
    case (q.st)
      ST_IDLE: begin
        d.osc = 1'b0;  // [R05]
      end
      ST_STBY: begin
        if (fall) begin
          d.st  = ST_HLOW;
          d.osc = 1'b1;  // [R05]
        end
      end
      ST_HLOW: begin
        if (rise) begin
          d.st    = ST_HMEAS;
          d.hcnt  = '0;
          d.edges = '0;
        end
      end
      ST_HMEAS: begin
        d.hcnt = q.hcnt + 1'b1;  // [R01]
        if (q.hcnt == HDR_MAX) begin
          d.st = ST_IDLE;  // [R02]
        end else if (any_edge) begin
          d.edges = q.edges + 1'b1;
          // ninth edge opens the master_ack slot: eight periods seen
          if (q.edges == HDR_EDGES) begin
            d.te  = period_of(q.hcnt);  // [R01] [R22]
            d.t   = period_of(q.hcnt) >> 1;
            d.st  = ST_BIT;
            d.idx = swl_pkg::SLOT_MAK;
            d.stg = STG_HDR;  // [R19]
          end
        end
      end
      ST_BIT: begin
        d.t = q.t + 1'b1;
        if (any_edge && q.t >= win_lo) begin
          d.t = '0;  // [R04]
          if (q.idx == swl_pkg::SLOT_MAK) begin
            d.master_ack = rise;  // [R20]
            d.te  = trim(q.te, q.t + 1'b1);  // [R03] [R24]
            d.st  = ST_SLOT;
            d.ack = 1'b0;
            case (q.stg)
              STG_HDR: begin
                d.stg = STG_ADDR;  // [R06] [R21]
              end
              STG_ADDR: begin
                if (EXT_ADDR && q.sh == {swl_pkg::FAM_EXT, FAMILY}) begin
                  d.stg = STG_ADDRL;  // [R11] [R21]
                end else if (!EXT_ADDR && q.sh == {FAMILY, dev_code[3:0]}) begin
                  d.stg   = STG_DATA;  // [R07]
                  d.ack   = 1'b1;
                  d.sel   = 1'b1;
                  d.first = 1'b1;
                end else begin
                  d.st = ST_IDLE;  // [R10] [R14] [R23]
                end
              end
              STG_ADDRL: begin
                if (q.sh == dev_code) begin
                  d.stg   = STG_DATA;  // [R12]
                  d.ack   = 1'b1;
                  d.sel   = 1'b1;
                  d.first = 1'b1;
                end else begin
                  d.st = ST_IDLE;  // [R23]
                end
              end
              default: begin
                d.ack      = 1'b1;  // [R16]
                d.rx_valid = 1'b1;
                d.rx_cmd   = q.first;  // [R15]
                d.rx_last  = ~rise;  // [R17]
                d.first    = 1'b0;
              end
            endcase
          end else begin
            d.sh  = {q.sh[6:0], rise};  // [R18]
            d.idx = q.idx + 1'b1;
          end
        end else if (q.t > win_hi) begin
          d.st = ST_IDLE;  // missed middle edge
        end
      end
      ST_SLOT: begin
        // own slot: low first half, rise at mid, let go a quarter early
        // so the master can take the line back without a clash
        d.t = q.t + 1'b1;
        if (q.t == half) begin
          d.oe  = q.ack;  // [R20] [R21]
          d.out = 1'b0;
        end else if (q.t == q.te) begin
          d.out = 1'b1;
        end else if (q.t == q.te + quarter) begin
          d.oe = 1'b0;
          if (!q.master_ack) begin
            d.st  = q.ack ? ST_STBY : ST_IDLE;  // [R17]
            d.sel = 1'b0;
            d.osc = 1'b0;
          end else begin
            d.st  = ST_BIT;
            d.idx = '0;
            d.t   = quarter;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // standby pulse ends any command
    if (q.hi_cnt == STB_MAX && q.st != ST_STBY) begin
      d.st  = ST_STBY;  // [R23]
      d.oe  = 1'b0;
      d.sel = 1'b0;
      d.osc = 1'b0;  // [R05]
    end
    if (d.st == ST_IDLE) begin
      d.oe  = 1'b0;
      d.sel = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.s_out  = q.out;
  assign bus.s_oe   = q.oe;
  assign o_rx_data  = q.sh;
  assign o_rx_valid = q.rx_valid;
  assign o_rx_cmd   = q.rx_cmd;
  assign o_rx_last  = q.rx_last;
  assign o_selected = q.sel;
  assign o_osc_en   = q.osc;
endmodule
`default_nettype wire

// [hw/swl_master.sv]
/*
  master end of the single-wire link: standby pulse, start header,
  byte transmit with master_ack or master_nack, slave_ack sampling.
  assumes the swl_if carrier and a 200 MHz i_sys_clk; the request
  port is driven by logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module swl_master #(
  parameter int unsigned TE_CYC   = 4000,
  parameter int unsigned STBY_CYC = swl_pkg::TSTBY_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  swl_if.master_mp        bus,
  input  wire logic       i_req_valid,
  input  wire logic [7:0] i_req_data,
  input  wire logic       i_req_first,
  input  wire logic       i_req_standby,
  input  wire logic       i_req_last,
  output logic            o_req_ready,
  output logic            o_resp_valid,
  output logic            o_resp_sak,
  output logic            o_resp_err,
  output logic            o_busy
);
  localparam int unsigned HALF  = TE_CYC / 2;
  localparam int unsigned DIV_W = $clog2(HALF);
  localparam int unsigned CNT_W = $clog2(STBY_CYC + 1);
  localparam logic [DIV_W-1:0] HALF_END = DIV_W'(HALF - 1);
  localparam logic [DIV_W-1:0] QTR      = DIV_W'(HALF / 2);
  localparam logic [CNT_W-1:0] STBY_END = CNT_W'(STBY_CYC - 1);
  localparam logic [CNT_W-1:0] HDR_END  = CNT_W'(swl_pkg::HEADER_LOW_TIME_CYC - 1);
  localparam logic [CNT_W-1:0] TSS_END  = CNT_W'(swl_pkg::TSS_CYC - 1);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TE_CYC < swl_pkg::TE_MIN_CYC || TE_CYC > swl_pkg::TE_MAX_CYC ||
      TE_CYC % 4 != 0 || STBY_CYC <= swl_pkg::TSS_CYC) begin : g_bad_param
    $error("master bit period or standby count out of range");
  end

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_STBY = 3'b001,
    M_HLOW = 3'b010,
    M_BIT  = 3'b011,
    M_SLOT = 3'b100,
    M_GAP  = 3'b101
  } mst_t;

  typedef struct packed {
    mst_t             st;
    logic [CNT_W-1:0] cnt;
    logic [DIV_W-1:0] div;
    logic             half;
    logic [3:0]       idx;
    logic [8:0]       sh;
    logic             last;
    logic             hdr;
    logic             pv;
    logic [7:0]       pd;
    logic             pl;
    logic             s0;
    logic             s1;
    logic             out;
    logic             oe;
    logic             rdy;
    logic             rv;
    logic             rsak;
    logic             rerr;
    logic             busy;
  } mst_q_t;

  mst_q_t q;
  mst_q_t d;

  logic lvl;
  logic tick;

  // first address byte may not carry a reserved family
  function automatic logic addr_bad(input logic [7:0] b);
    addr_bad = (b[7:4] == swl_pkg::FAM_NONE) ||
               (b[7:4] == swl_pkg::FAM_EXT && swl_pkg::fam_reserved(b[3:0]));
  endfunction

  swl_line_sampler u_smp (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_line    (bus.single_line_io),
    .o_level   (lvl),
    .o_rise    (),
    .o_fall    ()
  );

  assign tick = (q.div == HALF_END);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.rv   = 1'b0;
    d.rerr = 1'b0;
    d.cnt  = q.cnt + 1'b1;
    // half-bit divider runs only while bits move
    if (q.st == M_BIT || q.st == M_SLOT) begin
      d.div = tick ? '0 : q.div + 1'b1;
    end else begin
      d.div = '0;
    end
    // next byte of a running frame
    if (i_req_valid && q.rdy && q.st != M_IDLE) begin
      d.pv = 1'b1;  // [R16]
      d.pd = i_req_data;
      d.pl = i_req_last;
    end
    case (q.st)
      M_IDLE: begin
        d.oe = 1'b0;
        if (i_req_valid && q.rdy) begin
          if (!i_req_first || addr_bad(i_req_data)) begin
            d.rerr = 1'b1;  // [R06] [R09] [R13] [R14]
          end else begin
            d.pv  = 1'b1;
            d.pd  = i_req_data;
            d.pl  = i_req_last;
            d.hdr = 1'b1;
            d.cnt = '0;
            d.oe  = 1'b1;
            d.out = i_req_standby;
            d.st  = i_req_standby ? M_STBY : M_HLOW;
          end
        end
      end
      M_STBY: begin
        if (q.cnt == STBY_END) begin
          d.st  = M_HLOW;
          d.out = 1'b0;
          d.cnt = '0;
        end
      end
      M_HLOW: begin
        if (q.cnt == HDR_END) begin
          d.st   = M_BIT;  // [R19]
          d.sh   = {swl_pkg::HDR_PATTERN, 1'b1};
          d.last = 1'b0;
          d.idx  = '0;
          d.half = 1'b0;
          d.out  = ~swl_pkg::HDR_PATTERN[7];
        end
      end
      M_BIT: begin
        if (tick) begin
          if (!q.half) begin
            d.half = 1'b1;
            d.out  = q.sh[8];  // [R18]
          end else begin
            d.half = 1'b0;
            d.sh   = {q.sh[7:0], 1'b0};
            d.idx  = q.idx + 1'b1;
            if (q.idx == swl_pkg::SLOT_MAK) begin
              d.st = M_SLOT;  // [R20]
              d.oe = 1'b0;
            end else begin
              d.out = ~q.sh[7];
            end
          end
        end
      end
      M_SLOT: begin
        if (q.div == QTR) begin
          if (!q.half) begin
            d.s0 = lvl;
          end else begin
            d.s1 = lvl;
          end
        end
        if (tick) begin
          d.half = ~q.half;
          if (q.half) begin
            d.rv   = ~q.hdr;
            d.rsak = ~q.s0 & q.s1;  // [R20]
            if (q.last) begin
              d.st  = M_GAP;  // [R17]
              d.cnt = '0;
            end else if (q.pv) begin
              d.st   = M_BIT;  // [R15] [R16]
              d.sh   = {q.pd, ~q.pl};  // [R17]
              d.last = q.pl;
              d.pv   = 1'b0;
              d.hdr  = 1'b0;
              d.idx  = '0;
              d.oe   = 1'b1;
              d.out  = ~q.pd[7];
            end else begin
              d.st   = M_IDLE;
              d.rerr = 1'b1;
            end
          end
        end
      end
      M_GAP: begin
        d.oe = 1'b0;
        if (q.cnt == TSS_END) begin
          d.st = M_IDLE;
        end
      end
      default: begin
        d.st = M_IDLE;
      end
    endcase
    d.rdy  = (d.st == M_IDLE) ||
             ((d.st == M_BIT || d.st == M_SLOT) && !d.pv && !d.last);
    d.busy = (d.st != M_IDLE);
  end

  // state register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.m_out    = q.out;
  assign bus.m_oe     = q.oe;
  assign o_req_ready  = q.rdy;
  assign o_resp_valid = q.rv;
  assign o_resp_sak   = q.rsak;
  assign o_resp_err   = q.rerr;
  assign o_busy       = q.busy;
endmodule
`default_nettype wire

// [sim/swl_checker.sv]
/* link checker on the carrier signals and slave status.
   assumes one master end and one slave end on the carrier. */
`timescale 1ns/100ps
`default_nettype none
module swl_checker (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_m_oe,
  input wire logic i_s_out,
  input wire logic i_s_oe,
  input wire logic i_selected,
  input wire logic i_osc_en,
  input wire logic i_rx_valid,
  input wire logic i_rx_last
);
  localparam int LAST_MAX = 8000;
  logic        sel_q;
  logic        last_q;
  logic [15:0] wait_q;
  // ----------
  // helper state
  // ----------
  // selection seen in frame, cycles after final byte
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_q  <= 1'b0;
      last_q <= 1'b0;
      wait_q <= 16'h0000;
    end else begin
      sel_q  <= i_selected | (sel_q & i_osc_en);
      last_q <= (i_rx_valid & i_rx_last) | (last_q & i_selected);
      wait_q <= last_q ? wait_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------
  // properties
  // ----------
  a_single_driver: assert property (!(i_m_oe && i_s_oe)) else $error("two drivers");
  a_ack_after_match: assert property ($rose(i_s_oe) |-> sel_q || i_selected)
    else $error("ack before match");
  a_rx_after_match: assert property (i_rx_valid |-> sel_q || i_selected)
    else $error("byte while unselected");
  a_ack_low_first: assert property ($rose(i_s_oe) |-> (i_s_oe && !i_s_out)[*8])
    else $error("ack not low first");
  a_release_high: assert property ($fell(i_s_oe) |-> $past(i_s_out))
    else $error("released low");
  a_rx_one_pulse: assert property (i_rx_valid |=> !i_rx_valid)
    else $error("byte strobe too long");
  a_end_bounded: assert property (wait_q <= LAST_MAX)
    else $error("command end missed");
  a_quiet_when_off: assert property (!i_osc_en |-> !i_s_oe)
    else $error("drive while stopped");
  c_ack: cover property ($rose(i_s_oe));
  c_last: cover property (i_rx_valid && i_rx_last);
  c_wait: cover property (last_q);
endmodule
`default_nettype wire

// [sim/testbench.sv]
/* top bench: master and slave ends on one carrier.
   assumes slave family 4'h2 and a 10 us bit period. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       sys_clk;
  logic       sys_rst;
  logic       req_valid;
  logic [7:0] req_data;
  logic       req_first;
  logic       req_last;
  logic [7:0] dev_code;
  logic       req_ready;
  logic       resp_valid;
  logic       resp_sak;
  logic       resp_err;
  logic       busy;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_cmd;
  logic       rx_last;
  logic       selected;
  logic       osc_en;
  logic [9:0] rx_log [$];
  logic       sak_log [$];
  logic [7:0] bad [3] = '{8'h05, 8'hF0, 8'hFF};
  int         n_err = 0;
  int         n_fail = 0;
  int         compares = 0;

  swl_if link ();
  swl_master #(.TE_CYC(2000), .STBY_CYC(4800)) swl_master_i (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .bus(link), .i_req_valid(req_valid),
    .i_req_data(req_data), .i_req_first(req_first), .i_req_standby(req_first),
    .i_req_last(req_last), .o_req_ready(req_ready), .o_resp_valid(resp_valid),
    .o_resp_sak(resp_sak), .o_resp_err(resp_err), .o_busy(busy));
  swl_slave #(.STBY_CYC(4800)) swl_slave_i (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .bus(link), .i_dev_code(dev_code),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_cmd(rx_cmd), .o_rx_last(rx_last),
    .o_selected(selected), .o_osc_en(osc_en));
  swl_checker swl_checker_i (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_m_oe(link.m_oe), .i_s_out(link.s_out),
    .i_s_oe(link.s_oe), .i_selected(selected), .i_osc_en(osc_en), .i_rx_valid(rx_valid),
    .i_rx_last(rx_last));

  // ----------
  // clock and logging
  // ----------
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // log responses, received bytes, refusals
  always @(negedge sys_clk) begin
    if (resp_valid === 1'b1) sak_log.push_back(resp_sak);
    if (rx_valid === 1'b1) rx_log.push_back({rx_cmd, rx_last, rx_data});
    if (resp_err === 1'b1) n_err++;
  end

  // ----------
  // tasks
  // ----------
  task automatic close_out;
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // one bounded wait step, gives up after the limit
  task automatic step(input int t);
    if (t >= 90000) begin
      n_fail++;
      close_out;
    end else begin
      @(negedge sys_clk);
    end
  endtask
  // request one byte, held until taken while ready
  task automatic send(input logic [7:0] d, input logic first, input logic last);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_data  = d;
    req_first = first;
    req_last  = last;
    for (int t = 0; req_ready !== 1'b1; t++) step(t);
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  task automatic await_idle(input int n);
    for (int t = 0; sak_log.size() < n || busy !== 1'b0; t++) step(t);
  endtask

  // ----------
  // sequence
  // ----------
  // refusals, full command, extended address
  initial begin
    sys_rst   = 1'b1;
    req_valid = 1'b0;
    req_data  = 8'h00;
    req_first = 1'b0;
    req_last  = 1'b0;
    dev_code  = 8'h05;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_bit("idle line", 1'b1, link.single_line_io);
    foreach (bad[i]) send(bad[i], 1'b1, 1'b1);
    repeat (4) @(negedge sys_clk);
    chk_bit("refused", 1'b1, n_err == 3);
    chk_bit("busy", 1'b0, busy);
    send(8'h25, 1'b1, 1'b0);
    send(8'hA5, 1'b0, 1'b0);
    send(8'h3C, 1'b0, 1'b1);
    await_idle(3);
    foreach (sak_log[i]) chk_bit("slave ack", 1'b1, sak_log[i]);
    chk_word("command byte", {2'b10, 8'hA5}, rx_log[0]);
    chk_word("final byte", {2'b01, 8'h3C}, rx_log[1]);
    chk_bit("selected", 1'b0, selected);
    send(8'hF2, 1'b1, 1'b1);
    await_idle(4);
    chk_bit("extended ack", 1'b0, sak_log[3]);
    chk_bit("byte count", 1'b1, rx_log.size() == 2);
    chk_bit("osc after idle", 1'b0, osc_en);
    close_out;
  end
endmodule
`default_nettype wire
